// >>> lsc_pkg.sv
package lsc_pkg;
	localparam logic [15:0] LSC_CONTROL_ADDR = 16'h8040;
	localparam logic [15:0] LSC_STATUS_ADDR = 16'h8041;
	localparam logic [15:0] LSC_COUNT_ADDR = 16'h8042;
	localparam logic [15:0] LSC_CONTROL_RESET = 16'h0000;
	localparam int LSC_STOP_SEL_LSB = 6;
	localparam int LSC_DIV_LSB = 4;
	localparam int LSC_START_SEL_LSB = 2;
	localparam int LSC_ENABLE_BIT = 1;
	localparam int LSC_CLK_SEL_BIT = 0;
	localparam int LSC_CONTROL_USED = 8;
	localparam int LSC_START_FOUND_LSB = 12;
	localparam int LSC_STOP_FOUND_LSB = 8;
	localparam int LSC_READY_BIT = 4;
	localparam int LSC_COUNT_W = 20;
	localparam int LSC_COUNT_LOW_W = 16;
	localparam int LSC_DIV_MAX = 8;
	localparam logic [1:0] LSC_SEL_LOW_SPEED = 2'h0;
	localparam logic [1:0] LSC_SEL_HIGH_SPEED = 2'h1;
	localparam logic [2:0] LSC_HALF_PERIODS_PER_TICK = 3'h2;

	typedef enum logic [1:0] {
		LSC_IDLE,
		LSC_RUN,
		LSC_DONE
	} lsc_state_t;
endpackage : lsc_pkg

// >>> lsc_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
module lsc_tick_gen
	import lsc_pkg::*;
#(
	parameter int DIV_MAX = LSC_DIV_MAX
)
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// setup
	input wire logic clock_select,
	input wire logic [1:0] clock_divide,
	input wire logic byte_clk_tick,
	// measurement clock tick
	output logic tick
);
	// elaboration check
	if (DIV_MAX != 8)
	begin : g_div_max_check
		$error("lsc_tick_gen: DIV_MAX must be 8");
	end

	typedef struct packed {
		logic [2:0] cnt;
		logic tick;
	} lsc_tick_st_t;

	lsc_tick_st_t st, next_st;
	logic [2:0] mask;

	always_comb
	begin
		next_st = st;
		mask = 3'h0;
		case (clock_divide)
			2'h0: mask = 3'h0;
			2'h1: mask = 3'h1;
			2'h2: mask = 3'h3;
			2'h3: mask = 3'h7;
			default: mask = 3'h0;
		endcase
		if (clock_select)
		begin
			next_st.cnt = 3'h0;
			next_st.tick = byte_clk_tick;
		end
		else if (st.cnt >= mask)
		begin
			next_st.cnt = 3'h0;
			next_st.tick = 1'b1;
		end
		else
		begin
			next_st.cnt = st.cnt + 3'h1;
			next_st.tick = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick = st.tick;
endmodule : lsc_tick_gen
`default_nettype wire

// >>> lsc_stopwatch.sv
`timescale 1ns/1ns
`default_nettype none
module lsc_stopwatch
	import lsc_pkg::*;
#(
	parameter int COUNT_W = LSC_COUNT_W
)
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// markers
	input wire logic [3:0] ls_tx_marker,
	input wire logic [1:0] hs_rx_marker,
	input wire logic [3:0] ls_rx_marker,
	input wire logic [1:0] hs_tx_marker,
	input wire logic external_marker_pin,
	// recovered byte clock as tick
	input wire logic byte_clk_tick,
	// status
	output logic stopwatch_done_flag,
	output logic stopwatch_running
);
	// elaboration checks
	if (COUNT_W != LSC_COUNT_W)
	begin : g_count_w_check
		$error("lsc_stopwatch: COUNT_W must be 20");
	end

	if (LSC_COUNT_LOW_W >= COUNT_W)
	begin : g_count_split_check
		$error("lsc_stopwatch: count word split does not fit");
	end

	typedef struct packed {
		logic [LSC_CONTROL_USED-1:0] control;
		lsc_state_t state;
		logic [COUNT_W-1:0] stopwatch_count;
		logic [3:0] start_marker_found;
		logic [3:0] stop_marker_found;
		logic done;
		logic running;
		logic [15:0] rdata;
		logic rvalid;
	} lsc_st_t;

	lsc_st_t st, next_st;
	logic tick;
	logic [1:0] start_sel;
	logic [1:0] stop_sel;
	logic [1:0] clock_divide;
	logic enable;
	logic clock_select;
	logic [3:0] start_hits;
	logic [3:0] stop_hits;
	logic count_read;
	logic stop_now;
	logic [COUNT_W-1:0] shown_count;

	function automatic logic [3:0] lsc_pick(input logic [1:0] sel, input logic [3:0] ls,
		input logic [1:0] hs, input logic pin);
		if (sel == LSC_SEL_LOW_SPEED)
			return ls;
		else if (sel == LSC_SEL_HIGH_SPEED)
			return {2'h0, hs};
		else
			return {3'h0, pin};
	endfunction : lsc_pick

	function automatic logic [COUNT_W-1:0] lsc_sat_add(input logic [COUNT_W-1:0] v);
		logic [COUNT_W:0] sum;
		sum = {1'b0, v} + {{(COUNT_W-2){1'b0}}, LSC_HALF_PERIODS_PER_TICK};
		if (sum[COUNT_W])
			return {COUNT_W{1'b1}};
		else
			return sum[COUNT_W-1:0];
	endfunction : lsc_sat_add

	// count reads as zero until the measurement is complete
	function automatic logic [COUNT_W-1:0] lsc_shown_count(input logic done,
		input logic [COUNT_W-1:0] v);
		if (done)
			return v;
		else
			return '0;
	endfunction : lsc_shown_count

	function automatic logic [15:0] lsc_status_word(input logic [3:0] start_found,
		input logic [3:0] stop_found, input logic done, input logic [3:0] count_high);
		logic [15:0] w;
		w = 16'h0000;
		w[LSC_START_FOUND_LSB +: 4] = start_found;
		w[LSC_STOP_FOUND_LSB +: 4] = stop_found;
		w[LSC_READY_BIT] = done;
		w[3:0] = count_high;
		return w;
	endfunction : lsc_status_word

	assign start_sel = st.control[LSC_START_SEL_LSB +: 2];
	assign stop_sel = st.control[LSC_STOP_SEL_LSB +: 2];
	assign clock_divide = st.control[LSC_DIV_LSB +: 2];
	assign enable = st.control[LSC_ENABLE_BIT];
	assign clock_select = st.control[LSC_CLK_SEL_BIT];
	assign start_hits = lsc_pick(start_sel, ls_tx_marker, hs_rx_marker, external_marker_pin);
	assign stop_hits = lsc_pick(stop_sel, ls_rx_marker, hs_tx_marker, external_marker_pin);
	assign count_read = reg_rd && (reg_addr == LSC_COUNT_ADDR);
	// a stop landing with a count read completes the measurement
	assign stop_now = enable && (st.state == LSC_RUN) && (stop_hits != 4'h0);
	assign shown_count = lsc_shown_count(st.done, st.stopwatch_count);

	lsc_tick_gen #(
		.DIV_MAX(LSC_DIV_MAX)
	) u_tick (
		.clk(clk),
		.arst_n(arst_n),
		.clock_select(clock_select),
		.clock_divide(clock_divide),
		.byte_clk_tick(byte_clk_tick),
		.tick(tick)
	);

	always_comb
	begin
		next_st = st;
		next_st.rvalid = reg_rd;
		// register write
		if (reg_wr && reg_addr == LSC_CONTROL_ADDR)
			next_st.control = reg_wdata[LSC_CONTROL_USED-1:0];
		if (reg_rd)
		begin
			case (reg_addr)
				LSC_CONTROL_ADDR:
					next_st.rdata = {8'h00, st.control};
				LSC_STATUS_ADDR:
					next_st.rdata = lsc_status_word(st.start_marker_found, st.stop_marker_found,
						st.done, shown_count[COUNT_W-1:LSC_COUNT_LOW_W]);
				LSC_COUNT_ADDR:
					next_st.rdata = shown_count[LSC_COUNT_LOW_W-1:0];
				default:
					next_st.rdata = 16'h0000;
			endcase
		end
		// count-word read clears the result unless a stop lands in the same cycle
		if (count_read && !stop_now)
		begin
			next_st.stopwatch_count = '0;
			next_st.start_marker_found = 4'h0;
			next_st.stop_marker_found = 4'h0;
			next_st.done = 1'b0;
			next_st.state = LSC_IDLE;
		end
		if (!enable)
			next_st.state = LSC_IDLE;
		else
		begin
			case (next_st.state)
				LSC_IDLE:
				begin
					if (start_hits != 4'h0)
					begin
						next_st.state = LSC_RUN;
						next_st.stopwatch_count = '0;
						next_st.start_marker_found = start_hits;
						next_st.stop_marker_found = 4'h0;
						next_st.done = 1'b0;
					end
				end
				LSC_RUN:
				begin
					if (tick && !count_read)
						next_st.stopwatch_count = lsc_sat_add(st.stopwatch_count);
					if (stop_hits != 4'h0)
					begin
						next_st.state = LSC_DONE;
						next_st.stop_marker_found = stop_hits;
						next_st.done = 1'b1;
					end
				end
				LSC_DONE:
					next_st.state = LSC_DONE;
				default:
					next_st.state = LSC_IDLE;
			endcase
		end
		next_st.running = (next_st.state == LSC_RUN);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st <= '0;
			st.control <= LSC_CONTROL_RESET[LSC_CONTROL_USED-1:0];
			st.state <= LSC_IDLE;
		end
		else
			st <= next_st;
	end

	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign stopwatch_done_flag = st.done;
	assign stopwatch_running = st.running;
endmodule : lsc_stopwatch
`default_nettype wire

// >>> lsc_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module lsc_assertions
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	// markers and status
	input wire logic [3:0] ls_tx_marker,
	input wire logic [1:0] hs_rx_marker,
	input wire logic [3:0] ls_rx_marker,
	input wire logic [1:0] hs_tx_marker,
	input wire logic external_marker_pin,
	input wire logic stopwatch_done_flag,
	input wire logic stopwatch_running
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	read_answer_a:
		assert property (reg_rvalid == $past(reg_rd)) else $error("late read answer");
	ctrl_readback_a:
		assert property (reg_wr && reg_addr == 16'h8040 ##2 reg_rd && reg_addr == 16'h8040
			|=> reg_rdata == {8'h0, $past(reg_wdata[7:0], 3)}) else $error("bad readback");
	clear_done_a:
		assert property (reg_rd && reg_addr == 16'h8042 |=> !stopwatch_done_flag)
		else $error("done not cleared");
	done_hold_a:
		assert property (stopwatch_done_flag && !reg_rd && !reg_wr
			|=> stopwatch_done_flag || stopwatch_running) else $error("done dropped");
	one_state_a:
		assert property (!(stopwatch_done_flag && stopwatch_running)) else $error("done and run");
	run_start_a:
		assert property ($rose(stopwatch_running)
			|-> $past(|{ls_tx_marker, hs_rx_marker, external_marker_pin})) else $error("no start");
	done_stop_a:
		assert property ($rose(stopwatch_done_flag) |-> $past(stopwatch_running)
			&& $past(|{ls_rx_marker, hs_tx_marker, external_marker_pin})) else $error("no stop");
	run_end_a:
		assert property ($fell(stopwatch_running)
			|-> stopwatch_done_flag || $past(reg_rd) || $past(reg_wr, 2)) else $error("run lost");
endmodule : lsc_assertions
`default_nettype wire

// >>> test_latency_stopwatch_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_latency_stopwatch_control;
	logic clk = 0, arst_n = 0, wr_s = 0, rd_s = 0, pin = 0, bt = 0, rv, dn, run;
	logic [15:0] addr = 0, wd = 0, rdt, q, s;
	logic [3:0] ls_tx = 0, ls_rx = 0;
	logic [1:0] hs_rx = 0, hs_tx = 0;
	int failures = 0, check_count = 0, cyc = 0;
	lsc_stopwatch dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wr(wr_s),
		.reg_wdata(wd), .reg_rd(rd_s), .reg_rdata(rdt), .reg_rvalid(rv),
		.ls_tx_marker(ls_tx), .hs_rx_marker(hs_rx), .ls_rx_marker(ls_rx),
		.hs_tx_marker(hs_tx), .external_marker_pin(pin), .byte_clk_tick(bt),
		.stopwatch_done_flag(dn), .stopwatch_running(run));
	initial forever #20 clk = ~clk;
	task end_of_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc > 6000)
		begin
			failures++;
			end_of_test;
		end
	end
	task chk(input string n, input logic [19:0] sn, e);
		check_count++;
		if (sn !== e)
		begin
			failures++;
			$display("[FAIL] %s exp %h seen %h", n, e, sn);
		end
	endtask : chk
	task wr(input logic [15:0] a, d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1;
		@(posedge clk);
		wr_s <= 0;
	endtask : wr
	task rd(input logic [15:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1;
		@(posedge clk);
		rd_s <= 0;
		#1 q = rdt;
		chk("rvalid", rv, 1);
	endtask : rd
	task mark(input logic [1:0] m, input logic stp, output logic [3:0] f);
		int r;
		logic [5:0] v;
		r = $urandom_range(0, 3);
		f = m[1] ? 4'h1 : m[0] ? 4'(1 << r[0]) : 4'(1 << r);
		v = m[1] ? 6'h0 : m[0] ? {f[1:0], 4'h0} : {2'h0, f};
		@(posedge clk);
		pin <= m[1];
		if (stp)
			{hs_tx, ls_rx} <= v;
		else
			{hs_rx, ls_tx} <= v;
		@(posedge clk);
		{pin, hs_tx, ls_rx, hs_rx, ls_tx} <= 13'h0;
	endtask : mark
	task meas(input logic [7:0] c, input int n);
		logic [3:0] fs, fp;
		int d, v, dv;
		dv = 1 << c[5:4];
		wr(16'h8040, {8'h0, c});
		mark(c[3:2], 0, fs);
		d = cyc;
		rd(16'h8041);
		chk("busy", q, c[1] ? {fs, 12'h000} : 16'h0000);
		chk("running", run, c[1]);
		repeat (n)
		begin
			@(posedge clk);
			bt <= 1;
			@(posedge clk);
			bt <= 0;
			repeat (6) @(posedge clk);
		end
		mark(c[7:6], 1, fp);
		d = cyc - d;
		rd(16'h8041);
		s = q;
		chk("done", dn, c[1]);
		rd(16'h8042);
		chk("found", s[15:4], c[1] ? {fs, fp, 4'h1} : 12'h0);
		v = {s[3:0], q} * dv - 2 * d;
		if (!c[1] || c[0])
			chk("count", {s[3:0], q}, c[1] ? 2 * n : 0);
		else
			chk("span", v <= 2 * dv && v >= -2 * dv, 1);
		rd(16'h8041);
		chk("cleared", q, 0);
	endtask : meas
	initial
	begin
		void'($urandom(16));
		repeat (5) @(posedge clk);
		arst_n <= 1;
		rd(16'h8040);
		chk("ctrl reset", q, 0);
		wr(16'h8040, 16'hff3c);
		rd(16'h8040);
		chk("ctrl", q, 16'h003c);
		rd(16'h8043);
		chk("unmapped", q, 0);
		for (int i = 0; i < 16; i++)
			meas({i[1:0], i[3:2], i[3:2], 1'b1, i[0]}, 8 + $urandom_range(0, 4));
		meas(8'($urandom) & 8'hfd, 3);
		meas(8'($urandom) | 8'h03, 5);
		end_of_test;
	end
endmodule : test_latency_stopwatch_control
bind lsc_stopwatch lsc_assertions chk_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .ls_tx_marker(ls_tx_marker), .hs_rx_marker(hs_rx_marker),
	.ls_rx_marker(ls_rx_marker), .hs_tx_marker(hs_tx_marker),
	.external_marker_pin(external_marker_pin), .stopwatch_done_flag(stopwatch_done_flag),
	.stopwatch_running(stopwatch_running));
`default_nettype wire
